// File: include/spi_mem_pkg.sv
// Constants shared by the serial memory slave: opcodes, status layout,
// protection bounds and frame states.
// Assumes a synchronous, active-high reset and one system clock.
package spi_mem_pkg;
	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] WRITE_CMD = 8'h02;
	localparam logic [7:0] READ_CMD = 8'h03;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	// ----------------------------------------------------------------
	// Array geometry and protection bounds
	// ----------------------------------------------------------------
	localparam int MEM_ADDR_W = 15;
	localparam int MEM_DEPTH = 32768;
	localparam logic [14:0] TOP_ADDR = 15'h7FFF;
	localparam logic [14:0] WRAP_ADDR = 15'h0000;
	localparam logic [14:0] QUARTER_BASE = 15'h6000;
	localparam logic [14:0] HALF_BASE = 15'h4000;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	// ----------------------------------------------------------------
	// Status register layout
	// ----------------------------------------------------------------
	localparam int SR_WEL = 1;
	localparam int SR_BP0 = 2;
	localparam int SR_BP1 = 3;
	localparam int SR_WPEN = 7;
	localparam logic [7:0] SR_WR_MASK = 8'h8C;
	localparam logic [7:0] SR_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Synchroniser reset: chip select and protect pin idle high
	// ----------------------------------------------------------------
	localparam logic [3:0] SYNC_RESET = 4'h9;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// ----------------------------------------------------------------
	// Frame states
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_CMD = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_WDATA = 7'b0000100,
		ST_RDATA = 7'b0001000,
		ST_SRWR = 7'b0010000,
		ST_SRRD = 7'b0100000,
		ST_IGNORE = 7'b1000000
	} frame_state_t;
endpackage

// File: core/spi_serial_memory_slave.sv
// Command decoder, 32K x 8 array and serial shifter of an SPI memory slave.
// Assumes the SPI pins are asynchronous and much slower than ref_clk;
// the master drives chip select, clock and data, and samples spiMiso.
`timescale 1ns/1ns
// Notes on behaviour
// - Writes are accepted only after a write-enable opcode 06h.
// - Write frame: opcode 02h, two address bytes, then data bytes.
// - Top bit of the sixteen-bit address is dropped.
// - Each written data byte goes to the next location.
// - Address counter wraps from 7FFFh to 0000h.
// - Write data is shifted in most significant bit first.
// - Chip select rising ends a write; a new frame is needed.
// - Read frame: opcode 03h followed by two address bytes.
// - After the address, the addressed byte goes out over eight clocks.
// - Serial input is ignored while read data shifts out.
// - Reads continue at successive addresses, most significant bit first.
// - Chip select rising ends a read and releases the output.
// - Opcode 01h writes the status register.
// - Works in SPI mode 0 and mode 3.
// - The array holds 32K bytes.
// - Block protection guards upper quarter, upper half or all.
// - Protect pin can block status writes when enabled.
// - Write-disable opcode clears the write permission.
// - Opcode 05h returns the status byte.
module spi_serial_memory_slave
	import spi_mem_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic spiCsN,
	input wire logic spiSck,
	input wire logic spiMosi,
	input wire logic wpN,
	output logic spiMiso,
	output logic spiMisoOe
);
	localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int ENT_W = MEM_ADDR_W + 8;

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [3:0] syncA_reg, syncB_reg;
	logic sckPrev_reg, csPrev_reg;
	logic csN, sck, mosi, wpSyncN;
	logic sckRise, sckFall, csRise;
	// Two flops per pin; only the second stage feeds logic
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			syncA_reg <= SYNC_RESET;
			syncB_reg <= SYNC_RESET;
			sckPrev_reg <= 1'b0;
			csPrev_reg <= 1'b1;
		end else if (clkEn) begin
			syncA_reg <= {wpN, spiMosi, spiSck, spiCsN};
			syncB_reg <= syncA_reg;
			sckPrev_reg <= syncB_reg[1];
			csPrev_reg <= syncB_reg[0];
		end
	end
	assign csN = syncB_reg[0];
	assign sck = syncB_reg[1];
	assign mosi = syncB_reg[2];
	assign wpSyncN = syncB_reg[3];
	// Idle level of the clock is irrelevant: only edges inside a frame count
	assign sckRise = sck & ~sckPrev_reg & ~csN;
	assign sckFall = ~sck & sckPrev_reg & ~csN;
	assign csRise = csN & ~csPrev_reg;

	// ----------------------------------------------------------------
	// Frame state
	// ----------------------------------------------------------------
	frame_state_t state_reg;
	logic [2:0] bitCnt_reg;
	logic [6:0] shiftIn_reg, addrHi_reg;
	logic addrHiSeen_reg, isRead_reg, wrFrame_reg, fetchReq_reg, srLoad_reg;
	logic [MEM_ADDR_W-1:0] addrReg;
	logic [7:0] statusReg_reg, byteVal;
	logic byteDone, wel, addrProtected, pushReq, fillReady;
	assign byteVal = {shiftIn_reg, mosi};
	assign byteDone = sckRise && (bitCnt_reg == LAST_BIT);
	assign wel = statusReg_reg[SR_WEL];
	// Block protection decode on the current write address
	always_comb begin
		case (statusReg_reg[SR_BP1:SR_BP0])
			BP_NONE: addrProtected = 1'b0;
			BP_QUARTER: addrProtected = (addrReg >= QUARTER_BASE);
			BP_HALF: addrProtected = (addrReg >= HALF_BASE);
			default: addrProtected = 1'b1;
		endcase
	end
	assign pushReq = byteDone && (state_reg == ST_WDATA) && !addrProtected;
	// Bit counter and input shifter; frame resets while chip select is high
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bitCnt_reg <= 3'h0;
			shiftIn_reg <= 7'h00;
		end else if (clkEn) begin
			if (csN) begin
				bitCnt_reg <= 3'h0;
				shiftIn_reg <= 7'h00;
			end else if (sckRise) begin
				bitCnt_reg <= bitCnt_reg + 3'h1;
				shiftIn_reg <= byteVal[6:0];
			end
		end
	end
	// Command decoder and address counter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= ST_CMD;
			addrHi_reg <= 7'h00;
			addrHiSeen_reg <= 1'b0;
			isRead_reg <= 1'b0;
			wrFrame_reg <= 1'b0;
			fetchReq_reg <= 1'b0;
			srLoad_reg <= 1'b0;
			addrReg <= WRAP_ADDR;
		end else if (clkEn) begin
			fetchReq_reg <= 1'b0;
			srLoad_reg <= 1'b0;
			if (csN) begin
				state_reg <= ST_CMD;
				addrHiSeen_reg <= 1'b0;
				wrFrame_reg <= 1'b0;
			end else if (byteDone) begin
				case (state_reg)
					ST_CMD: begin
						isRead_reg <= (byteVal == READ_CMD);
						if (byteVal == READ_CMD) begin
							state_reg <= ST_ADDR;
						end else if (byteVal == WRITE_CMD && wel) begin
							state_reg <= ST_ADDR;
							wrFrame_reg <= 1'b1;
						end else if (byteVal == STATUS_WRITE_CMD && wel) begin
							state_reg <= ST_SRWR;
							wrFrame_reg <= 1'b1;
						end else if (byteVal == STATUS_READ_CMD) begin
							state_reg <= ST_SRRD;
							srLoad_reg <= 1'b1;
						end else begin
							state_reg <= ST_IGNORE;
						end
					end
					ST_ADDR: begin
						if (!addrHiSeen_reg) begin
							addrHi_reg <= byteVal[6:0];
							addrHiSeen_reg <= 1'b1;
						end else begin
							addrReg <= {addrHi_reg, byteVal};
							if (isRead_reg) begin
								state_reg <= ST_RDATA;
								fetchReq_reg <= 1'b1;
							end else begin
								state_reg <= ST_WDATA;
							end
						end
					end
					ST_WDATA: begin
						addrReg <= addrReg + 15'h0001;
					end
					ST_RDATA: begin
						// Input bits are discarded; only the count matters
						addrReg <= addrReg + 15'h0001;
						fetchReq_reg <= 1'b1;
					end
					ST_SRWR: state_reg <= ST_IGNORE;
					ST_SRRD: srLoad_reg <= 1'b1;
					ST_IGNORE: state_reg <= ST_IGNORE;
					default: state_reg <= ST_IGNORE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Status register
	// ----------------------------------------------------------------
	// Enable and disable come only inside a frame, the end-of-frame clear
	// only at chip select rising, so the events never collide.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			statusReg_reg <= SR_RESET;
		end else if (clkEn) begin
			if (csRise && wrFrame_reg) begin
				statusReg_reg[SR_WEL] <= 1'b0;
			end else if (byteDone && state_reg == ST_CMD) begin
				if (byteVal == WRITE_ENABLE_CMD) begin
					statusReg_reg[SR_WEL] <= 1'b1;
				end else if (byteVal == WRITE_DISABLE_CMD) begin
					statusReg_reg[SR_WEL] <= 1'b0;
				end
			end else if (byteDone && state_reg == ST_SRWR) begin
				if (wpSyncN || !statusReg_reg[SR_WPEN]) begin
					statusReg_reg <= (byteVal & SR_WR_MASK) |
						(statusReg_reg & ~SR_WR_MASK);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Write buffer between the shifter and the array
	// ----------------------------------------------------------------
	// Array fetches take the single port first; the buffer then holds
	// write bytes so none is lost while draining stalls.
	logic [ENT_W-1:0] buf_reg [BUF_DEPTH];
	logic [PTR_W-1:0] wrPtr_reg, rdPtr_reg;
	logic [PTR_W:0] count_reg;
	logic drainValid, drainReady, push, pop;
	logic [7:0] mem [MEM_DEPTH];
	assign fillReady = (count_reg != (PTR_W + 1)'(BUF_DEPTH));
	assign drainValid = (count_reg != '0);
	assign drainReady = !fetchReq_reg;
	assign push = pushReq && fillReady;
	assign pop = drainValid && drainReady;
	// Pointers and occupancy
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else if (clkEn) begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
	// Buffer storage and array write port
	always_ff @(posedge ref_clk) begin
		if (clkEn) begin
			if (push) begin
				buf_reg[wrPtr_reg] <= {addrReg, byteVal};
			end
			if (pop) begin
				mem[buf_reg[rdPtr_reg][ENT_W-1:8]] <= buf_reg[rdPtr_reg][7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Output path
	// ----------------------------------------------------------------
	logic [7:0] txByte_reg, outShift_reg;
	// Next byte to send: array fetch or status snapshot
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txByte_reg <= 8'h00;
		end else if (clkEn) begin
			if (fetchReq_reg) begin
				txByte_reg <= mem[addrReg];
			end else if (srLoad_reg) begin
				txByte_reg <= statusReg_reg;
			end
		end
	end
	// Drive on falling clock so data is settled before the master samples
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			spiMiso <= 1'b0;
			spiMisoOe <= 1'b0;
			outShift_reg <= 8'h00;
		end else if (clkEn) begin
			if (csN) begin
				spiMiso <= 1'b0;
				spiMisoOe <= 1'b0;
			end else if (sckFall && (state_reg == ST_RDATA || state_reg == ST_SRRD)) begin
				spiMisoOe <= 1'b1;
				if (bitCnt_reg == 3'h0) begin
					{spiMiso, outShift_reg} <= {txByte_reg, 1'b0};
				end else begin
					{spiMiso, outShift_reg} <= {outShift_reg, 1'b0};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst || !clkEn);
	sequence seqCmd(logic [7:0] op);
		byteDone && state_reg == ST_CMD && byteVal == op;
	endsequence
	sequence seqLastAddr;
		byteDone && state_reg == ST_ADDR && addrHiSeen_reg;
	endsequence
	chk_write_needs_wel: assert property (
		seqCmd(WRITE_CMD) ##0 !wel |=> state_reg == ST_IGNORE)
		else $error("write accepted without enable");
	chk_wel_sets: assert property (seqCmd(WRITE_ENABLE_CMD) |=> wel)
		else $error("enable opcode did not set permission");
	chk_wel_disable: assert property (seqCmd(WRITE_DISABLE_CMD) |=> !wel)
		else $error("disable opcode did not clear permission");
	chk_wel_frame_end: assert property (csRise && wrFrame_reg |=> !wel)
		else $error("permission kept after write frame");
	chk_addr_drop_msb: assert property (
		seqLastAddr |=> addrReg == {$past(addrHi_reg), $past(byteVal)})
		else $error("address not built from low fifteen bits");
	chk_addr_wrap: assert property (
		byteDone && state_reg == ST_WDATA && addrReg == TOP_ADDR |=> addrReg == WRAP_ADDR)
		else $error("address did not wrap");
	chk_read_holds: assert property (
		byteDone && state_reg == ST_RDATA |=> state_reg == ST_RDATA ##0 fetchReq_reg)
		else $error("read left data phase or skipped fetch");
	chk_read_first: assert property (
		seqLastAddr ##0 isRead_reg |=> state_reg == ST_RDATA && fetchReq_reg)
		else $error("read did not start after address");
	chk_msb_first: assert property (
		sckFall && state_reg == ST_RDATA && bitCnt_reg == 3'h0 |=> spiMiso == $past(txByte_reg[7]))
		else $error("read byte not sent msb first");
	chk_cs_release: assert property (csRise |=> !spiMisoOe && state_reg == ST_CMD)
		else $error("frame not ended on chip select rise");
	// Bounds recomputed from the address bits, not from the decode above
	chk_protect: assert property (push |->
		statusReg_reg[SR_BP1:SR_BP0] == BP_NONE ||
		(statusReg_reg[SR_BP1:SR_BP0] == BP_QUARTER && (addrReg & QUARTER_BASE) != QUARTER_BASE) ||
		(statusReg_reg[SR_BP1:SR_BP0] == BP_HALF && (addrReg & HALF_BASE) != HALF_BASE))
		else $error("protected location queued for write");
	chk_buf_drain: assert property (drainValid && !fetchReq_reg |=> count_reg <= $past(count_reg))
		else $error("buffer did not drain");
endmodule

// File: tb/spi_master_model.sv
// Bus master model for the serial memory slave: drives select, clock and data.
// Assumes the bench resolves the slave's data-out wire and calls tasks in order.
`timescale 1ns/1ns
module spi_master_model (
	output logic spiCsN,
	output logic spiSck,
	output logic spiMosi,
	input wire logic misoWire
);
	// ----------------------------------------------------------------
	// Idle state
	// ----------------------------------------------------------------
	logic cpol;
	// Clock parks at the idle level of the chosen mode
	initial begin
		cpol = 1'b0;
		spiCsN = 1'b1;
		spiSck = 1'b0;
		spiMosi = 1'b1;
	end
	// ----------------------------------------------------------------
	// Frame tasks
	// ----------------------------------------------------------------
	// Clock settles before select falls, so no stray edge opens a byte
	task automatic open_frame();
		spiSck = cpol;
		#50;
		spiCsN = 1'b0;
		#50;
	endtask
	// One byte, top bit first; data read at the end of the high phase,
	// since the slave answers a few system clocks after the falling edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (cpol) spiSck = 1'b0;
			spiMosi = tx[i];
			#40 spiSck = 1'b1;
			#39 rx[i] = misoWire;
			#1;
			if (!cpol) spiSck = 1'b0;
		end
	endtask
	// Released data line flips so a stale level is never mistaken for data
	task automatic close_frame();
		#40 spiCsN = 1'b1;
		spiMosi = ~spiMosi;
		#100;
	endtask
endmodule

// File: tb/spi_serial_memory_slave_bench.sv
// Self-checking bench for the serial memory slave.
// Assumes the master model sits on the link pins and the wire is resolved here.
`timescale 1ns/1ns
module spi_serial_memory_slave_bench;
	import spi_mem_pkg::*;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic ref_clk;
	logic rst;
	logic clkEn;
	logic wpN;
	logic spiCsN;
	logic spiSck;
	logic spiMosi;
	logic spiMiso;
	logic spiMisoOe;
	wire misoWire;
	logic [7:0] txq[$];
	logic [7:0] rxq[$];
	int miscompares;
	int samplesChecked;
	// Nobody else drives the data line, so it floats when released
	assign misoWire = spiMisoOe ? spiMiso : 1'bz;
	spi_serial_memory_slave spi_serial_memory_slave_inst (
		.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .spiCsN(spiCsN), .spiSck(spiSck),
		.spiMosi(spiMosi), .wpN(wpN), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe));
	spi_master_model spi_master_model_inst (
		.spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi), .misoWire(misoWire));
	// 100 MHz system clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
		samplesChecked++;
		if (seen !== expected) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, expected, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Sends txq as one frame; answers land in rxq
	task automatic frame(input logic expOe);
		logic [7:0] rx;
		rxq = {};
		spi_master_model_inst.open_frame();
		foreach (txq[i]) begin
			spi_master_model_inst.xfer(txq[i], rx);
			rxq.push_back(rx);
		end
		check("enable in frame", {7'h00, spiMisoOe}, {7'h00, expOe});
		spi_master_model_inst.close_frame();
		check("released output", {6'h00, spiMisoOe, spiMiso}, 8'h00);
	endtask
	task automatic write_enable_cmd();
		txq = '{WRITE_ENABLE_CMD};
		frame(1'b0);
	endtask
	task automatic read_status(output logic [7:0] s);
		txq = '{STATUS_READ_CMD, 8'h00};
		frame(1'b1);
		s = rxq[1];
	endtask
	task automatic set_status(input logic [7:0] v);
		write_enable_cmd();
		txq = '{STATUS_WRITE_CMD, v};
		frame(1'b0);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Permission, sequential write across the top, refused write, read-back
	task automatic test_write_wrap();
		logic [7:0] s;
		write_enable_cmd();
		read_status(s);
		check("status after enable", s, 8'h02);
		txq = '{WRITE_CMD, 8'h80, 8'h10, 8'h3C, 8'h66};
		frame(1'b0);
		read_status(s);
		check("status after write", s, 8'h00);
		txq = '{WRITE_CMD, 8'h00, 8'h10, 8'h11};
		frame(1'b0);
		write_enable_cmd();
		txq = '{WRITE_CMD, 8'hFF, 8'hFE, 8'hA1, 8'hB2, 8'hC3};
		frame(1'b0);
		txq = '{READ_CMD, 8'h7F, 8'hFE, 8'h5A, 8'hA5, 8'h5A};
		frame(1'b1);
		check("read at 7FFE", rxq[3], 8'hA1);
		check("read at 7FFF", rxq[4], 8'hB2);
		check("read after wrap", rxq[5], 8'hC3);
		txq = '{READ_CMD, 8'h80, 8'h10, 8'hFF, 8'hFF};
		frame(1'b1);
		check("unenabled write kept out", rxq[3], 8'h3C);
		check("second write byte", rxq[4], 8'h66);
		$display("test_write_wrap done");
	endtask
	// Write-disable, block protection and the protect pin
	task automatic test_protect();
		logic [7:0] s;
		write_enable_cmd();
		txq = '{WRITE_DISABLE_CMD};
		frame(1'b0);
		read_status(s);
		check("status after disable", s, 8'h00);
		set_status(8'h8C);
		read_status(s);
		check("status after status write", s, 8'h8C);
		write_enable_cmd();
		txq = '{WRITE_CMD, 8'h00, 8'h11, 8'h99};
		frame(1'b0);
		txq = '{READ_CMD, 8'h00, 8'h11, 8'h00};
		frame(1'b1);
		check("protected byte unchanged", rxq[3], 8'h66);
		@(negedge ref_clk) wpN <= 1'b0;
		set_status(8'h00);
		read_status(s);
		check("pin blocks status write", s & 8'hFD, 8'h8C);
		@(negedge ref_clk) wpN <= 1'b1;
		set_status(8'h00);
		read_status(s);
		check("status cleared", s, 8'h00);
		$display("test_protect done");
	endtask
	// Quarter and half bounds, both sides of each; a frame while clkEn is low
	task automatic test_block_ranges();
		logic [7:0] s;
		write_enable_cmd();
		txq = '{WRITE_CMD, 8'h3F, 8'hFF, 8'h11, 8'h22};
		frame(1'b0);
		write_enable_cmd();
		txq = '{WRITE_CMD, 8'h5F, 8'hFF, 8'h33, 8'h44};
		frame(1'b0);
		set_status(8'h04);
		write_enable_cmd();
		txq = '{WRITE_CMD, 8'h5F, 8'hFF, 8'h55, 8'h66};
		frame(1'b0);
		set_status(8'h08);
		@(negedge ref_clk) clkEn <= 1'b0;
		write_enable_cmd();
		@(negedge ref_clk) clkEn <= 1'b1;
		read_status(s);
		check("status kept while frozen", s, 8'h08);
		write_enable_cmd();
		txq = '{WRITE_CMD, 8'h3F, 8'hFF, 8'h77, 8'h88};
		frame(1'b0);
		txq = '{READ_CMD, 8'h3F, 8'hFF, 8'h00, 8'h00};
		frame(1'b1);
		check("below half bound", rxq[3], 8'h77);
		check("half bound kept", rxq[4], 8'h22);
		txq = '{READ_CMD, 8'h5F, 8'hFF, 8'h00, 8'h00};
		frame(1'b1);
		check("below quarter bound", rxq[3], 8'h55);
		check("quarter bound kept", rxq[4], 8'h44);
		set_status(8'h00);
		$display("test_block_ranges done");
	endtask
	// Same write and read with the clock idling high
	task automatic test_mode3();
		spi_master_model_inst.cpol = 1'b1;
		write_enable_cmd();
		txq = '{WRITE_CMD, 8'h12, 8'h34, 8'h5A, 8'hA5};
		frame(1'b0);
		txq = '{READ_CMD, 8'h12, 8'h34, 8'h00, 8'h00};
		frame(1'b1);
		check("mode 3 first byte", rxq[3], 8'h5A);
		check("mode 3 second byte", rxq[4], 8'hA5);
		spi_master_model_inst.cpol = 1'b0;
		$display("test_mode3 done");
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		miscompares = 0;
		samplesChecked = 0;
		rst = 1'b1;
		clkEn = 1'b1;
		wpN = 1'b1;
		repeat (5) @(negedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(negedge ref_clk);
		test_write_wrap();
		test_protect();
		test_block_ranges();
		test_mode3();
		tally_and_finish();
	end
	// Tests need about 86 us; a hung handshake ends the run here
	initial begin
		#400000;
		miscompares++;
		$display("Error watchdog expected done seen running");
		tally_and_finish();
	end
endmodule
